// ==== common/gst_pkg.sv ====
// package: register map, field layout and carrier types of the gated sixteen bit timer
package gst_pkg;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
	localparam logic [7:0] OFS_GATE_CTRL  = 8'h04;
	localparam logic [7:0] OFS_OSC_CTRL   = 8'h08;
	localparam logic [7:0] OFS_OSC_CTRL2  = 8'h0C;
	localparam logic [7:0] OFS_COUNT      = 8'h10;
	localparam logic [7:0] OFS_IRQ_FLAG   = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h18;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int POS_TIMER_ON      = 0;
	localparam int POS_SOSC_EN       = 3;
	localparam int POS_CS_LO         = 6;
	localparam int POS_GATE_EN       = 7;
	localparam int POS_GATE_POL      = 6;
	localparam int POS_GATE_TOGGLE   = 5;
	localparam int POS_GATE_SPM      = 4;
	localparam int POS_ACQ_GO        = 3;
	localparam int POS_GATE_VAL      = 2;
	localparam int POS_GSS_LO        = 0;
	localparam int POS_NEW_OSC_SELECT_LO       = 0;
	localparam int POS_SOSC_WARMUP   = 1;
	localparam int POS_GATE_EVT_FLAG = 2;

	// overflow flag / enable bit for instances 1, 3 and 5 (index 0, 1, 2)
	localparam int POS_OVF_INST0 = 0;
	localparam int POS_OVF_INST1 = 1;
	localparam int POS_OVF_INST2 = 1;

	// ****************************************************************
	// encodings and reset values
	// ****************************************************************
	localparam logic [2:0]  NEW_OSC_SELECT_SECONDARY = 3'h4;
	localparam logic [1:0]  GSS_PIN        = 2'h0;
	localparam logic [1:0]  GSS_MATCH      = 2'h1;
	localparam logic [1:0]  GSS_CMP1       = 2'h2;
	localparam logic [1:0]  GSS_CMP2       = 2'h3;
	localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
	localparam logic [15:0] COUNT_RST      = 16'h0000;
	localparam logic [7:0]  REG8_RST       = 8'h00;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef struct packed {
		logic       gate_count_en;
		logic       gate_polarity;
		logic       gate_toggle_mode;
		logic       gate_single_pulse_en;
		logic       acquisition_go;
		logic       gate_value_status;
		logic [1:0] gate_source_select;
	} gst_gate_ctrl_t;

	typedef struct packed {
		logic [1:0] clock_source_select;
		logic [1:0] prescale_unused;
		logic       sec_osc_timer_en;
		logic [1:0] sync_rd16_unused;
		logic       timer_on;
	} gst_timer_ctrl_t;

	typedef struct packed {
		logic gate_pin;
		logic cmp1_output_bit;
		logic cmp2_output_bit;
	} gst_gate_in_t;

endpackage : gst_pkg

// ==== src/gst_timer.sv ====
// design: gate, counter, flags and AXI4-Lite register slave of the gated sixteen bit timer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - run secondary oscillator if timer osc enable, warm-up bit, or new-osc select is 100
// - gate control bit 7 enables gate counting, bit 6 sets gate polarity
// - while gate active, counter advances on each selected clock rising edge
// - polarity 0 counts on low gate, polarity 1 counts on high gate
// - gate source select: 00 pin, 01 companion match, 10 cmp1, 11 cmp2
// - companion period match produces a gate pulse one instruction cycle high
// - match source: polarity 1 counts only that cycle, polarity 0 all others
// - comparator source makes gate follow comparator output level
// - toggle mode routes gate through flip-flop toggling on each incrementing edge
// - toggle flip-flop held clear while toggle mode is off
// - single pulse counts from next incrementing edge, go clears at trailing edge
// - after acquisition completes, ignore gate events until go is set again
// - clearing single pulse enable also clears acquisition go
// - toggle plus single pulse counts exactly one full gate source period
// - gate value status shows resolved gate level even with gating disabled
// - falling gate value sets gate event flag; request interrupt when enabled
// - gate event flag works regardless of gate count enable
// - counter runs 0000h to FFFFh, wraps to zero, sets overflow flag
// - overflow flag sits at bit 0, 1, 1 of flag register per instance
// - overflow interrupt requested only when matching enable bit is set
// - timer on with gate disabled counts freely; timer off ignores gate enable
module gst_timer #(
	parameter int INSTANCE = 0
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        timer_tick,
	input  wire logic        instr_tick,
	input  wire logic        companion_wrap,
	input  wire logic        gate_pin,
	input  wire logic        cmp1_output_bit,
	input  wire logic        cmp2_output_bit,
	output logic             sec_osc_run,
	output logic             overflow_irq,
	output logic             gate_event_irq
);

	localparam int OVF_POS = (INSTANCE == 0) ? gst_pkg::POS_OVF_INST0 :
	                         (INSTANCE == 1) ? gst_pkg::POS_OVF_INST1 :
	                                           gst_pkg::POS_OVF_INST2;

	typedef enum logic [1:0] {
		SP_IDLE,
		SP_ARMED,
		SP_ACTIVE
	} gst_sp_state_t;

	// ****************************************************************
	// declarations
	// ****************************************************************
	gst_pkg::gst_timer_ctrl_t tcon_q;
	gst_pkg::gst_gate_ctrl_t  gcon_q;
	logic [2:0]               new_osc_select_q;
	logic                     warmup_q;
	logic [15:0]              count_q;
	logic                     ovf_flag_q;
	logic                     gevt_flag_q;
	logic                     ovf_en_q;
	logic                     gevt_en_q;
	gst_pkg::gst_gate_in_t    raw_in;
	gst_pkg::gst_gate_in_t    sync1_q;
	gst_pkg::gst_gate_in_t    sync2_q;
	logic                     match_pulse_q;
	logic                     src_sel;
	logic                     gate_lvl;
	logic                     gate_lvl_q;
	logic                     tff_q;
	logic                     gate_t;
	logic                     gate_t_q;
	logic                     gate_res;
	logic                     gate_res_q;
	gst_sp_state_t            sp_q;
	logic                     count_inc;
	logic [7:0]               aw_addr_q;
	logic                     aw_held_q;
	logic [31:0]              w_data_q;
	logic [3:0]               w_strb_q;
	logic                     w_held_q;
	logic                     wr_fire;
	logic                     wr_hit;
	logic                     rd_fire;
	logic [31:0]              rd_val;
	logic                     rd_hit;
	logic                     wr_gcon;
	logic                     clr_ovf;
	logic                     clr_gevt;
	logic                     sp_done;

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	assign raw_in = '{gate_pin: gate_pin, cmp1_output_bit: cmp1_output_bit,
	                  cmp2_output_bit: cmp2_output_bit};

	// the first stage feeds only the second stage
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else if (clk_en) begin
					sync1_q[gi] <= raw_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// companion match pulse
	// ****************************************************************
	// held from the wrap until the end of the next instruction cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_pulse_q <= 1'b0;
		end else if (clk_en) begin
			if (companion_wrap) begin
				match_pulse_q <= 1'b1;
			end else if (instr_tick) begin
				match_pulse_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// gate resolution
	// ****************************************************************
	always_comb begin
		unique case (gcon_q.gate_source_select)
			gst_pkg::GSS_PIN:   src_sel = sync2_q.gate_pin;
			gst_pkg::GSS_MATCH: src_sel = match_pulse_q;
			gst_pkg::GSS_CMP1:  src_sel = sync2_q.cmp1_output_bit;
			gst_pkg::GSS_CMP2:  src_sel = sync2_q.cmp2_output_bit;
		endcase
	end

	// active-high gate after polarity
	assign gate_lvl = gcon_q.gate_polarity ? src_sel : ~src_sel;
	assign gate_t   = gcon_q.gate_toggle_mode ? tff_q : gate_lvl;
	assign gate_res = gcon_q.gate_single_pulse_en ?
	                  ((sp_q == SP_ACTIVE) & gate_t) : gate_t;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_lvl_q <= 1'b0;
			gate_t_q   <= 1'b0;
			gate_res_q <= 1'b0;
		end else if (clk_en) begin
			gate_lvl_q <= gate_lvl;
			gate_t_q   <= gate_t;
			gate_res_q <= gate_res;
		end
	end

	// toggle flip-flop flips on each rising edge of the polarised source
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tff_q <= 1'b0;
		end else if (clk_en) begin
			if (!gcon_q.gate_toggle_mode) begin
				tff_q <= 1'b0;
			end else if (gate_lvl & ~gate_lvl_q) begin
				tff_q <= ~tff_q;
			end
		end
	end

	// ****************************************************************
	// single pulse acquisition
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_q <= SP_IDLE;
		end else if (clk_en) begin
			if (!gcon_q.gate_single_pulse_en || !gcon_q.acquisition_go) begin
				sp_q <= SP_IDLE;
			end else begin
				unique case (sp_q)
					SP_IDLE: begin
						// a level already high does not start; wait for the edge
						sp_q <= gate_t ? SP_IDLE : SP_ARMED;
					end
					SP_ARMED: begin
						if (gate_t & ~gate_t_q) begin
							sp_q <= SP_ACTIVE;
						end
					end
					SP_ACTIVE: begin
						if (!gate_t) begin
							sp_q <= SP_IDLE;
						end
					end
				endcase
			end
		end
	end

	assign sp_done = (sp_q == SP_ACTIVE) & ~gate_t;

	// ****************************************************************
	// counter
	// ****************************************************************
	// timer off freezes the count whatever the gate bit says
	assign count_inc = tcon_q.timer_on & timer_tick &
	                   (~gcon_q.gate_count_en | gate_res);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= gst_pkg::COUNT_RST;
		end else if (clk_en) begin
			if (wr_fire && aw_addr_q == gst_pkg::OFS_COUNT) begin
				if (w_strb_q[0]) begin
					count_q[7:0] <= w_data_q[7:0];
				end
				if (w_strb_q[1]) begin
					count_q[15:8] <= w_data_q[15:8];
				end
			end else if (count_inc) begin
				count_q <= count_q + 16'h0001;
			end
		end
	end

	// ****************************************************************
	// flags (hardware set beats software clear)
	// ****************************************************************
	assign clr_ovf  = wr_fire && aw_addr_q == gst_pkg::OFS_IRQ_FLAG && w_strb_q[0] &&
	                  w_data_q[OVF_POS];
	assign clr_gevt = wr_fire && aw_addr_q == gst_pkg::OFS_IRQ_FLAG && w_strb_q[0] &&
	                  w_data_q[gst_pkg::POS_GATE_EVT_FLAG];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovf_flag_q <= 1'b0;
		end else if (clk_en) begin
			if (count_inc && count_q == gst_pkg::COUNT_MAX) begin
				ovf_flag_q <= 1'b1;
			end else if (clr_ovf) begin
				ovf_flag_q <= 1'b0;
			end
		end
	end

	// falling edge of the resolved gate, independent of the gate enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gevt_flag_q <= 1'b0;
		end else if (clk_en) begin
			if (gate_res_q & ~gate_res) begin
				gevt_flag_q <= 1'b1;
			end else if (clr_gevt) begin
				gevt_flag_q <= 1'b0;
			end
		end
	end

	assign overflow_irq   = ovf_flag_q & ovf_en_q;
	assign gate_event_irq = gevt_flag_q & gevt_en_q;
	assign sec_osc_run    = tcon_q.sec_osc_timer_en | warmup_q |
	                        (new_osc_select_q == gst_pkg::NEW_OSC_SELECT_SECONDARY);

	// ****************************************************************
	// control registers
	// ****************************************************************
	assign wr_gcon = wr_fire && aw_addr_q == gst_pkg::OFS_GATE_CTRL && w_strb_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tcon_q    <= gst_pkg::REG8_RST;
			new_osc_select_q    <= 3'h0;
			warmup_q  <= 1'b0;
			ovf_en_q  <= 1'b0;
			gevt_en_q <= 1'b0;
		end else if (clk_en && wr_fire && w_strb_q[0]) begin
			unique case (aw_addr_q)
				gst_pkg::OFS_TIMER_CTRL: tcon_q   <= w_data_q[7:0];
				gst_pkg::OFS_OSC_CTRL:   new_osc_select_q   <= w_data_q[gst_pkg::POS_NEW_OSC_SELECT_LO +: 3];
				gst_pkg::OFS_OSC_CTRL2:  warmup_q <= w_data_q[gst_pkg::POS_SOSC_WARMUP];
				gst_pkg::OFS_IRQ_EN: begin
					ovf_en_q  <= w_data_q[OVF_POS];
					gevt_en_q <= w_data_q[gst_pkg::POS_GATE_EVT_FLAG];
				end
				default: begin
				end
			endcase
		end
	end

	// gate control: the status bit is not stored, go is cleared by hardware
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gcon_q <= gst_pkg::REG8_RST;
		end else if (clk_en) begin
			if (wr_gcon) begin
				gcon_q                   <= w_data_q[7:0];
				gcon_q.gate_value_status <= 1'b0;
				gcon_q.acquisition_go    <= w_data_q[gst_pkg::POS_ACQ_GO] &
				                            w_data_q[gst_pkg::POS_GATE_SPM];
			end else if (!gcon_q.gate_single_pulse_en || sp_done) begin
				gcon_q.acquisition_go <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
	assign wr_fire       = aw_held_q & w_held_q & ~s_axi_bvalid;

	always_comb begin
		unique case (aw_addr_q)
			gst_pkg::OFS_TIMER_CTRL, gst_pkg::OFS_GATE_CTRL, gst_pkg::OFS_OSC_CTRL,
			gst_pkg::OFS_OSC_CTRL2, gst_pkg::OFS_COUNT, gst_pkg::OFS_IRQ_FLAG,
			gst_pkg::OFS_IRQ_EN: wr_hit = 1'b1;
			default:             wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_q    <= 8'h00;
			aw_held_q    <= 1'b0;
			w_data_q     <= 32'h00000000;
			w_strb_q     <= 4'h0;
			w_held_q     <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= gst_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
				aw_held_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_held_q <= 1'b1;
			end
			if (wr_fire) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid & s_axi_arready;

	always_comb begin
		rd_val = 32'h00000000;
		rd_hit = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			gst_pkg::OFS_TIMER_CTRL: rd_val[7:0] = tcon_q;
			gst_pkg::OFS_GATE_CTRL: begin
				rd_val[7:0]                  = gcon_q;
				rd_val[gst_pkg::POS_GATE_VAL] = gate_res;
			end
			gst_pkg::OFS_OSC_CTRL:   rd_val[2:0] = new_osc_select_q;
			gst_pkg::OFS_OSC_CTRL2:  rd_val[gst_pkg::POS_SOSC_WARMUP] = warmup_q;
			gst_pkg::OFS_COUNT:      rd_val[15:0] = count_q;
			gst_pkg::OFS_IRQ_FLAG: begin
				rd_val[OVF_POS]                    = ovf_flag_q;
				rd_val[gst_pkg::POS_GATE_EVT_FLAG] = gevt_flag_q;
			end
			gst_pkg::OFS_IRQ_EN: begin
				rd_val[OVF_POS]                    = ovf_en_q;
				rd_val[gst_pkg::POS_GATE_EVT_FLAG] = gevt_en_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= gst_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_hit ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : gst_timer
`default_nettype wire

// ==== sim/gst_timer_monitor.sv ====
// checker: bus handshake and output relations of the gated timer
`timescale 1ns/1ps
`default_nettype none
module gst_timer_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        clk_en,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        sec_osc_run,
	input wire logic        overflow_irq,
	input wire logic        gate_event_irq
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
	endsequence
	sequence s_wr_done;
		s_axi_bvalid && s_axi_bready && clk_en;
	endsequence
	chk_wr_answer: assert property (s_wr_take ##1 clk_en |=> s_axi_bvalid)
		else $error("write answer missing");
	chk_wr_close: assert property (s_wr_done |=> !s_axi_bvalid)
		else $error("write answer not released");
	chk_wr_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
		else $error("read answer missing");
	chk_rd_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == gst_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read with data");
	chk_osc_by_write: assert property (!$stable(sec_osc_run) |-> $rose(s_axi_bvalid))
		else $error("oscillator request changed without write");
	chk_out_reset: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> !overflow_irq && !gate_event_irq && !sec_osc_run)
		else $error("outputs active after reset");
endmodule : gst_timer_monitor
bind gst_timer gst_timer_monitor u_gst_timer_monitor (.aclk, .aresetn, .clk_en, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.sec_osc_run, .overflow_irq, .gate_event_irq);
`default_nettype wire

// ==== sim/gst_gate_src.sv ====
// partner: instruction strobe, companion timer and gate source levels
`timescale 1ns/1ps
`default_nettype none
module gst_gate_src #(
	parameter int PERIOD = 5
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [2:0] lvl,
	output logic           instr_tick,
	output logic           companion_wrap,
	output logic           gate_pin,
	output logic           cmp1_output_bit,
	output logic           cmp2_output_bit
);
	logic [1:0] div_q;
	logic [7:0] cnt_q;
	// instruction cycle is four clocks
	always_ff @(posedge aclk) begin
		if (!aresetn) div_q <= 2'h0;
		else div_q <= div_q + 2'h1;
	end
	assign instr_tick = div_q == 2'h3;
	// companion returns to zero on the step after reaching its period
	// the strobe stands in the very step of the return to zero
	assign companion_wrap = instr_tick && cnt_q == 8'(PERIOD);
	always_ff @(posedge aclk) begin
		if (!aresetn) cnt_q <= 8'h00;
		else if (companion_wrap) cnt_q <= 8'h00;
		else if (instr_tick) cnt_q <= cnt_q + 8'h01;
	end
	// levels change at bench pace, asynchronous to the timer's view
	assign {gate_pin, cmp1_output_bit, cmp2_output_bit} = lvl;
endmodule : gst_gate_src
`default_nettype wire

// ==== sim/testbench.sv ====
// testbench: registers, gate sources, single pulse, toggle and flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] A_TC = gst_pkg::OFS_TIMER_CTRL;
	localparam logic [7:0] A_GC = gst_pkg::OFS_GATE_CTRL;
	localparam logic [7:0] A_CNT = gst_pkg::OFS_COUNT;
	localparam logic [7:0] A_FLG = gst_pkg::OFS_IRQ_FLAG;
	localparam logic [7:0] A_EN = gst_pkg::OFS_IRQ_EN;
	localparam logic [1:0] OK = gst_pkg::RESP_OKAY;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        clk_en = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        timer_tick = 1'b0;
	logic [2:0]  lvl = 3'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, ms;
	logic        instr_tick, companion_wrap, gate_pin, cmp1_output_bit, cmp2_output_bit;
	logic        sec_osc_run, overflow_irq, gate_event_irq;
	logic [33:0] ex;
	logic [33:0] eq[$];
	logic [31:0] mq[$];
	int          errors = 0;
	int          n_compared = 0;
	always #12.5 aclk = ~aclk;
	gst_timer #(.INSTANCE(1)) u_gst_timer (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_tick, .instr_tick, .companion_wrap,
		.gate_pin, .cmp1_output_bit, .cmp2_output_bit, .sec_osc_run, .overflow_irq, .gate_event_irq);
	gst_gate_src #(.PERIOD(5)) u_gst_gate_src (.aclk, .aresetn, .lvl, .instr_tick, .companion_wrap,
		.gate_pin, .cmp1_output_bit, .cmp2_output_bit);
	// ****
	// helpers
	// ****
	task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task end_of_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	task tmo;
		chk("handshake", 34'h1, 34'h0);
		end_of_test;
	endtask : tmo
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		eq.push_back({r, 32'h0});
		mq.push_back(32'h0);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 20 && (pa || pw); i++) begin
			@(posedge aclk);
			if (s_axi_awready) pa = 1'b0;
			if (s_axi_wready) pw = 1'b0;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		if (i == 20) tmo;
		// late ready so a standing answer is exercised
		repeat (2) @(posedge aclk);
		s_axi_bready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge aclk);
			if (s_axi_bvalid) break;
		end
		if (i == 20) tmo;
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
		int i;
		eq.push_back({r, e & m});
		mq.push_back(m);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge aclk);
			if (s_axi_arready) break;
		end
		if (i == 20) tmo;
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge aclk);
			if (s_axi_rvalid) break;
		end
		if (i == 20) tmo;
		s_axi_rready <= 1'b0;
	endtask : rd
	task tk(input int n);
		repeat (n) begin
			timer_tick <= 1'b1;
			@(posedge aclk);
			timer_tick <= 1'b0;
			@(posedge aclk);
		end
	endtask : tk
	task lv(input logic [2:0] v);
		lvl <= v;
		repeat (6) @(posedge aclk);
	endtask : lv
	// answers are taken in order and compared with the oldest note
	always @(posedge aclk) begin
		if (aresetn && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
			if (eq.size() == 0) chk("note", 34'h0, 34'h1);
			else begin
				ex = eq.pop_front();
				ms = mq.pop_front();
				chk("answer", ex, s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata & ms});
			end
		end
	end
	// ****
	// scenarios
	// ****
	initial begin
		int s, p, en, b;
		logic [15:0] c;
		logic [2:0] v;
		logic g;
		void'($urandom(32'h953438F0));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (s = 0; s < 7; s++) rd(8'(4 * s), 32'h0, 32'hFFFF_FFFB, OK);
		rd(8'h1C, 32'h0, 32'hFFFF_FFFF, gst_pkg::RESP_SLVERR);
		wr(8'h1C, 32'hFF, gst_pkg::RESP_SLVERR);
		for (s = 0; s < 3; s++) begin
			b = 4 * s + ((s == 0) ? 0 : 4);
			wr(8'(b), (s == 0) ? 32'h88 : (s == 1) ? 32'h4 : 32'h2, OK);
			chk("osc run", 34'h1, {33'h0, sec_osc_run});
			wr(8'(b), (s == 1) ? 32'h5 : 32'h0, OK);
			chk("osc run", 34'h0, {33'h0, sec_osc_run});
		end
		wr(A_TC, 32'h1, OK);
		for (s = 0; s < 4; s++) for (p = 0; p < 4; p++) if (s != 1) begin
			en = $urandom % 2;
			c = 16'($urandom % 32'hFF00);
			b = (s == 0) ? 2 : 3 - s;
			v = 3'h1 << b;
			lv(p[0] ? v : ~v);
			wr(A_GC, {24'h0, en[0], p[1], 4'h0, s[1:0]}, OK);
			wr(A_CNT, {16'h0, c}, OK);
			tk(3);
			g = p[0] == p[1];
			rd(A_CNT, {16'h0, c + ((!en[0] || g) ? 16'h3 : 16'h0)}, 32'hFFFF, OK);
			rd(A_GC, {24'h0, en[0], p[1], 3'h0, g, s[1:0]}, 32'hFF, OK);
		end
		wr(A_GC, 32'h40, OK);
		lv(3'h4);
		wr(A_FLG, 32'hFF, OK);
		wr(A_EN, 32'h4, OK);
		chk("gate irq", 34'h0, {33'h0, gate_event_irq});
		lv(3'h0);
		rd(A_FLG, 32'h4, 32'h4, OK);
		chk("gate irq", 34'h1, {33'h0, gate_event_irq});
		wr(A_FLG, 32'h4, OK);
		chk("gate irq", 34'h0, {33'h0, gate_event_irq});
		wr(A_GC, 32'h41, OK);
		wr(A_FLG, 32'hFF, OK);
		repeat (60) @(posedge aclk);
		rd(A_FLG, 32'h4, 32'h4, OK);
		wr(A_GC, 32'h0, OK);
		wr(A_EN, 32'h0, OK);
		wr(A_CNT, 32'hFFFE, OK);
		wr(A_FLG, 32'hFF, OK);
		tk(2);
		rd(A_CNT, 32'h0, 32'hFFFF, OK);
		rd(A_FLG, 32'h1 << gst_pkg::POS_OVF_INST1, 32'h3, OK);
		chk("ovf irq", 34'h0, {33'h0, overflow_irq});
		wr(A_EN, 32'h2, OK);
		chk("ovf irq", 34'h1, {33'h0, overflow_irq});
		wr(A_TC, 32'h0, OK);
		wr(A_CNT, 32'h1234, OK);
		tk(3);
		rd(A_CNT, 32'h1234, 32'hFFFF, OK);
		wr(A_TC, 32'h1, OK);
		clk_en <= 1'b0;
		tk(3);
		clk_en <= 1'b1;
		rd(A_CNT, 32'h1234, 32'hFFFF, OK);
		wr(A_GC, 32'hD0, OK);
		wr(A_GC, 32'hD8, OK);
		wr(A_CNT, 32'h0, OK);
		lv(3'h4);
		tk(2);
		lv(3'h0);
		rd(A_GC, 32'hD0, 32'hFB, OK);
		lv(3'h4);
		tk(2);
		lv(3'h0);
		rd(A_CNT, 32'h2, 32'hFFFF, OK);
		wr(A_GC, 32'hC8, OK);
		rd(A_GC, 32'hC0, 32'hFB, OK);
		wr(A_GC, 32'hE0, OK);
		lv(3'h4);
		wr(A_CNT, 32'h0, OK);
		tk(2);
		lv(3'h0);
		tk(2);
		lv(3'h4);
		tk(2);
		rd(A_CNT, 32'h4, 32'hFFFF, OK);
		lv(3'h0);
		wr(A_GC, 32'hF0, OK);
		wr(A_GC, 32'hF8, OK);
		wr(A_CNT, 32'h0, OK);
		for (s = 0; s < 4; s++) begin
			lv(s[0] ? 3'h0 : 3'h4);
			tk(2);
		end
		rd(A_CNT, 32'h4, 32'hFFFF, OK);
		rd(A_GC, 32'hF0, 32'hF8, OK);
		end_of_test;
	end
endmodule : testbench
`default_nettype wire
